// [pkg/ext_bus_pkg.sv]
// Purpose: Shared constants for the external zone bus interface.
// Assumes: Register indices are 32-bit word indices; byte address is four times the index.
// Notes:   Timing fields count ticks of the interface timing clock.
package ext_bus_pkg;

  // Register indices
  localparam logic [11:0] IDX_ZONE0_TIMING = 12'hb20;
  localparam logic [11:0] IDX_ZONE1_TIMING = 12'hb22;
  localparam logic [11:0] IDX_ZONE2_TIMING = 12'hb24;
  localparam logic [11:0] IDX_ZONE6_TIMING = 12'hb2c;
  localparam logic [11:0] IDX_ZONE7_TIMING = 12'hb2e;
  localparam logic [11:0] IDX_BUS_CONFIG   = 12'hb34;
  localparam logic [11:0] IDX_BANK_CONTROL = 12'hb38;
  localparam logic [11:0] IDX_VERSION      = 12'hb3a;

  // Timing register fields
  localparam int SETUP_LSB = 0;
  localparam int SETUP_W   = 2;
  localparam int WAIT_LSB  = 2;
  localparam int WAIT_W    = 5;
  localparam int HOLD_LSB  = 7;
  localparam int HOLD_W    = 2;
  localparam logic [31:0] TIMING_MASK  = 32'h0000_01ff;
  localparam logic [31:0] TIMING_RESET = 32'h0000_01ff;

  // Configuration register fields
  localparam int CFG_HALF_BIT = 0;
  localparam int CFG_MODE_BIT = 8;
  localparam logic [31:0] CFG_MASK  = 32'h0000_0101;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;

  // Bank control and version
  localparam logic [31:0] BANK_MASK    = 32'h0000_ffff;
  localparam logic [31:0] BANK_RESET   = 32'h0000_0000;
  localparam logic [31:0] VERSION_MASK = 32'h0000_ffff;

  // Zone slots
  localparam int ZONE_SLOTS = 5;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD} bus_state_t;

endpackage

// [hdl/timing_tick.sv]
// Purpose: Tick enable for the interface timing clock, full or half rate.
// Assumes: Clock enable low freezes the phase.
// Notes:   Tick is combinational from a flop and the rate select.
`timescale 1ns/1ps
`default_nettype none
module timing_tick (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Rate select and tick
  input  wire logic half_i,
  output logic      tick_o
);

  logic phase;

  // Phase toggles only at half rate, so full rate ticks every cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase <= 1'b0;
    end else if (ce_i) begin
      phase <= half_i ? ~phase : 1'b0;
    end
  end

  assign tick_o = ~half_i | phase;

endmodule
`default_nettype wire

// [hdl/ext_zone_bus.sv]
// Purpose: External zone bus interface with AXI4-Lite register slave.
// Assumes: CPU requests are synchronous; external bus is asynchronous and unclocked.
// Notes:   Zone 7 strap is taken from the mode pin once after reset release.
//
// Function
// - The external bus is non-multiplexed with separate address and data, split in five zones.
// - Zone 7 is mapped by bit 8 of configuration, strapped from the mode pin after reset and writable afterwards.
// - Zones 0, 1, 2 and 6 are always decoded regardless of mode.
// - Each zone uses its own wait, setup and hold counts for every access to it.
// - A zone's select is asserted only while an access to that zone runs.
// - Zone 0 and zone 1 selects are ANDed into one shared output.
// - Zone 6 and zone 7 selects are ANDed into one shared output.
// - With zone 7 off, memory on the shared 6/7 select stays reachable through zone 6.
// - All timing counts tick at the system clock rate or half of it.
// - Timing and configuration registers take whole-word or 16-bit half writes.
// - A read-only version register returns a fixed code in bits 15 to 0.
// - The register block accepts both 16-bit and 32-bit accesses.
// - Register writes need no unprotect step.
`timescale 1ns/1ps
`default_nettype none
module ext_zone_bus #(
  parameter int          ADDR_W      = 19,
  parameter int          DATA_W      = 16,
  parameter int          AXI_ADDR_W  = 16,
  parameter logic [15:0] VERSION_CODE = 16'h00a5 // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Mode strap
  input  wire logic                  proc_mode_pin_i,
  // AXI4-Lite write address and data
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  output logic [1:0]                 s_axi_bresp_o,
  // AXI4-Lite read
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  // CPU access request
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire logic                  req_write_i,
  input  wire logic [2:0]            req_zone_i,
  input  wire logic [ADDR_W-1:0]     req_addr_i,
  input  wire logic [DATA_W-1:0]     req_wdata_i,
  // CPU access answer
  output logic                       req_done_o,
  output logic                       req_err_o,
  output logic [DATA_W-1:0]          req_rdata_o,
  // External bus
  output logic [ADDR_W-1:0]          ext_addr_o,
  output logic [DATA_W-1:0]          ext_data_o,
  output logic                       ext_data_oe_o,
  input  wire logic [DATA_W-1:0]     ext_data_i,
  output logic                       ext_rd_n_o,
  output logic                       ext_we_n_o,
  output logic                       zone01_select_n_o,
  output logic                       zone2_select_n_o,
  output logic                       zone67_select_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [31:0]                zone_timing [ext_bus_pkg::ZONE_SLOTS];
  logic [31:0]                bus_configuration;
  logic [31:0]                bank_control;
  logic                       strap_done;
  logic                       aw_full, w_full;
  logic [AXI_ADDR_W-1:0]      aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       wr_fire;
  logic [2:0]                 wr_slot, rd_slot;
  logic                       wr_hit, rd_hit;
  logic [31:0]                rd_value;
  ext_bus_pkg::bus_state_t    st;
  logic [4:0]                 cnt;
  logic [2:0]                 cur_zone;
  logic                       cur_write;
  logic                       tick;
  logic                       zone7_en;
  logic                       req_take;
  logic [31:0]                req_timing, cur_timing;
  logic [7:0]                 cs_n;

  // Slot: 0..4 are zone timing, 5 config, 6 bank, 7 version
  function automatic logic [3:0] decode(input logic [AXI_ADDR_W-1:0] a);
    logic [11:0] idx;
    idx = a[13:2];
    decode = 4'h0;
    if (a[AXI_ADDR_W-1:14] == '0 && a[1:0] == 2'h0) begin
      case (idx)
        ext_bus_pkg::IDX_ZONE0_TIMING: decode = 4'h8;
        ext_bus_pkg::IDX_ZONE1_TIMING: decode = 4'h9;
        ext_bus_pkg::IDX_ZONE2_TIMING: decode = 4'ha;
        ext_bus_pkg::IDX_ZONE6_TIMING: decode = 4'hb;
        ext_bus_pkg::IDX_ZONE7_TIMING: decode = 4'hc;
        ext_bus_pkg::IDX_BUS_CONFIG:   decode = 4'hd;
        ext_bus_pkg::IDX_BANK_CONTROL: decode = 4'he;
        ext_bus_pkg::IDX_VERSION:      decode = 4'hf;
        default:                       decode = 4'h0;
      endcase
    end
  endfunction

  // Byte-lane merge; half-word writes touch only their own lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // Zone number to timing slot
  function automatic logic [2:0] zone_slot(input logic [2:0] z);
    case (z)
      3'h0:    zone_slot = 3'h0;
      3'h1:    zone_slot = 3'h1;
      3'h2:    zone_slot = 3'h2;
      3'h6:    zone_slot = 3'h3;
      default: zone_slot = 3'h4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Address and data taken in either order, response once both held
  assign s_axi_awready_o = ce_i & ~aw_full & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ce_i & ~w_full & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ce_i & ~s_axi_rvalid_o;
  assign wr_fire         = ce_i & aw_full & w_full & ~s_axi_bvalid_o;
  assign {wr_hit, wr_slot} = decode(aw_addr);
  assign {rd_hit, rd_slot} = decode(s_axi_araddr_i);

  // Write channel capture and response
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= '0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= ext_bus_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // No unprotect step: every mapped writable register takes it
        s_axi_bresp_o  <= !wr_hit ? ext_bus_pkg::RESP_DECERR :
                          (wr_slot == 3'h7) ? ext_bus_pkg::RESP_SLVERR :
                          ext_bus_pkg::RESP_OKAY;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Read mux; upper half of 16-bit registers reads zero
  always_comb begin
    case (rd_slot)
      3'h5:    rd_value = bus_configuration;
      3'h6:    rd_value = bank_control;
      3'h7:    rd_value = {16'h0000, VERSION_CODE} & ext_bus_pkg::VERSION_MASK;
      default: rd_value = zone_timing[rd_slot];
    endcase
  end

  // Read answer one cycle after address taken
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= ext_bus_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_hit ? rd_value : 32'h0000_0000;
        s_axi_rresp_o  <= rd_hit ? ext_bus_pkg::RESP_OKAY : ext_bus_pkg::RESP_DECERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // One timing register per zone slot, byte-lane writable
  for (genvar s = 0; s < ext_bus_pkg::ZONE_SLOTS; s++) begin : g_timing
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        zone_timing[s] <= ext_bus_pkg::TIMING_RESET;
      end else if (ce_i && wr_fire && wr_hit && wr_slot == 3'(s)) begin
        zone_timing[s] <= merge(zone_timing[s], w_data, w_strb) & ext_bus_pkg::TIMING_MASK;
      end
    end
  end

  // Configuration: mode bit strapped from pin after reset, then writable
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bus_configuration <= ext_bus_pkg::CFG_RESET;
      strap_done        <= 1'b0;
    end else if (ce_i) begin
      if (!strap_done) begin
        bus_configuration[ext_bus_pkg::CFG_MODE_BIT] <= proc_mode_pin_i;
        strap_done                                   <= 1'b1;
      end else if (wr_fire && wr_hit && wr_slot == 3'h5) begin
        bus_configuration <= merge(bus_configuration, w_data, w_strb)
                             & ext_bus_pkg::CFG_MASK;
      end
    end
  end

  // Bank control is plain storage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bank_control <= ext_bus_pkg::BANK_RESET;
    end else if (ce_i && wr_fire && wr_hit && wr_slot == 3'h6) begin
      bank_control <= merge(bank_control, w_data, w_strb) & ext_bus_pkg::BANK_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  timing_tick u_tick (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .half_i  (bus_configuration[ext_bus_pkg::CFG_HALF_BIT]),
    .tick_o  (tick)
  );

  assign zone7_en    = bus_configuration[ext_bus_pkg::CFG_MODE_BIT];
  assign req_ready_o = ce_i & strap_done & (st == ext_bus_pkg::ST_IDLE);
  assign req_take    = req_valid_i & req_ready_o;
  assign req_timing  = zone_timing[zone_slot(req_zone_i)];
  assign cur_timing  = zone_timing[zone_slot(cur_zone)];

  // Each phase lasts field plus one ticks; refused zones answer with error
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st          <= ext_bus_pkg::ST_IDLE;
      cnt         <= 5'h00;
      cur_zone    <= 3'h0;
      cur_write   <= 1'b0;
      ext_addr_o  <= '0;
      ext_data_o  <= '0;
      req_done_o  <= 1'b0;
      req_err_o   <= 1'b0;
      req_rdata_o <= '0;
    end else if (ce_i) begin
      req_done_o <= 1'b0;
      req_err_o  <= 1'b0;
      case (st)
        ext_bus_pkg::ST_IDLE: begin
          if (req_take) begin
            case (req_zone_i)
              3'h0, 3'h1, 3'h2, 3'h6, 3'h7: begin
                if (req_zone_i != 3'h7 || zone7_en) begin
                  st         <= ext_bus_pkg::ST_SETUP;
                  cnt        <= 5'(req_timing[ext_bus_pkg::SETUP_LSB +: ext_bus_pkg::SETUP_W]);
                  cur_zone   <= req_zone_i;
                  cur_write  <= req_write_i;
                  ext_addr_o <= req_addr_i;
                  ext_data_o <= req_wdata_i;
                end else begin
                  req_err_o <= 1'b1;
                end
              end
              default: req_err_o <= 1'b1;
            endcase
          end
        end
        ext_bus_pkg::ST_SETUP: begin
          if (tick) begin
            if (cnt == 5'h00) begin
              st  <= ext_bus_pkg::ST_ACTIVE;
              cnt <= 5'(cur_timing[ext_bus_pkg::WAIT_LSB +: ext_bus_pkg::WAIT_W]);
            end else begin
              cnt <= cnt - 5'h01;
            end
          end
        end
        ext_bus_pkg::ST_ACTIVE: begin
          if (tick) begin
            if (cnt == 5'h00) begin
              st  <= ext_bus_pkg::ST_HOLD;
              cnt <= 5'(cur_timing[ext_bus_pkg::HOLD_LSB +: ext_bus_pkg::HOLD_W]);
              if (!cur_write) begin
                req_rdata_o <= ext_data_i;
              end
            end else begin
              cnt <= cnt - 5'h01;
            end
          end
        end
        ext_bus_pkg::ST_HOLD: begin
          if (tick) begin
            if (cnt == 5'h00) begin
              st         <= ext_bus_pkg::ST_IDLE;
              req_done_o <= 1'b1;
            end else begin
              cnt <= cnt - 5'h01;
            end
          end
        end
        default: st <= ext_bus_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pins

  // Per-zone select, low only while that zone's access runs
  for (genvar z = 0; z < 8; z++) begin : g_cs
    assign cs_n[z] = ~((st != ext_bus_pkg::ST_IDLE) && (cur_zone == 3'(z)));
  end

  // Shared selects; combinational decode of the state and zone flops, not registered
  assign zone01_select_n_o = cs_n[0] & cs_n[1];
  assign zone2_select_n_o  = cs_n[2];
  assign zone67_select_n_o = cs_n[6] & cs_n[7];

  // Strobes only in active phase; data driven for the whole write
  assign ext_rd_n_o    = ~((st == ext_bus_pkg::ST_ACTIVE) & ~cur_write);
  assign ext_we_n_o    = ~((st == ext_bus_pkg::ST_ACTIVE) & cur_write);
  assign ext_data_oe_o = (st != ext_bus_pkg::ST_IDLE) & cur_write;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_select_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    (st == ext_bus_pkg::ST_IDLE) |-> (zone01_select_n_o && zone2_select_n_o && zone67_select_n_o))
    else $error("zone select active while bus idle");

  chk_zone01_shared: assert property (@(posedge clock_i) disable iff (rst_i)
    (st != ext_bus_pkg::ST_IDLE && cur_zone inside {3'h0, 3'h1}) |-> !zone01_select_n_o
      && zone67_select_n_o)
    else $error("shared zone 0/1 select wrong");

  chk_zone67_shared: assert property (@(posedge clock_i) disable iff (rst_i)
    (st != ext_bus_pkg::ST_IDLE && cur_zone inside {3'h6, 3'h7}) |-> !zone67_select_n_o
      && zone01_select_n_o)
    else $error("shared zone 6/7 select wrong");

  chk_zone7_refused: assert property (@(posedge clock_i) disable iff (rst_i)
    (req_take && req_zone_i == 3'h7 && !zone7_en) |=> (req_err_o && st == ext_bus_pkg::ST_IDLE))
    else $error("zone 7 access not refused while unmapped");

  chk_fixed_zones: assert property (@(posedge clock_i) disable iff (rst_i)
    (req_take && req_zone_i inside {3'h0, 3'h1, 3'h2, 3'h6}) |=>
      (st == ext_bus_pkg::ST_SETUP && !req_err_o && cur_zone == $past(req_zone_i)))
    else $error("fixed zone access not started");

  chk_setup_load: assert property (@(posedge clock_i) disable iff (rst_i)
    req_take && req_zone_i != 3'h7 && req_zone_i inside {3'h0, 3'h1, 3'h2, 3'h6} |=>
      cnt == 5'($past(req_timing[ext_bus_pkg::SETUP_LSB +: ext_bus_pkg::SETUP_W])))
    else $error("setup count not taken from zone timing");

  chk_half_tick: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && bus_configuration[ext_bus_pkg::CFG_HALF_BIT]
      && $stable(bus_configuration[ext_bus_pkg::CFG_HALF_BIT]) && tick) |=>
      (!tick || !bus_configuration[ext_bus_pkg::CFG_HALF_BIT]))
    else $error("half rate tick on two cycles running");

  chk_version_read: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_axi_arvalid_i && s_axi_arready_o && rd_hit && rd_slot == 3'h7) |=>
      (s_axi_rvalid_o && s_axi_rdata_o == {16'h0000, VERSION_CODE}))
    else $error("version read wrong");

  chk_half_write: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_fire && wr_hit && wr_slot == 3'h6 && w_strb == 4'h3) |=>
      (bank_control[15:8] == $past(w_data[15:8]) && s_axi_bresp_o == ext_bus_pkg::RESP_OKAY))
    else $error("16-bit write not applied");

  cov_zone6_write: cover property (@(posedge clock_i) disable iff (rst_i)
    req_take && req_write_i && req_zone_i == 3'h6 ##[1:200] req_done_o);
  cov_zone7_read: cover property (@(posedge clock_i) disable iff (rst_i)
    req_take && !req_write_i && req_zone_i == 3'h7 ##[1:200] req_done_o);
  cov_reg_write: cover property (@(posedge clock_i) disable iff (rst_i)
    wr_fire && wr_hit && wr_slot == 3'h0);

endmodule
`default_nettype wire

// [tb/ext_mem_model.sv]
// Purpose: External memory model on the three zone select outputs.
// Assumes: Stores on the rising write strobe, fetches on the falling read strobe.
// Notes:   A released bus shows the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Bus from the interface
  input  wire logic [18:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        oe_i,
  input  wire logic        rd_n_i,
  input  wire logic        we_n_i,
  input  wire logic [2:0]  sel_n_i,
  // Read data back
  output logic [15:0]      data_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0;
  // One bank per select, so zones sharing a select share contents
  always @(posedge we_n_i) begin
    if (oe_i) mem[{sel_n_i, addr_i[4:0]}] <= data_i;
  end
  // Fetch at the start of the read strobe
  always @(negedge rd_n_i) begin
    last = mem[{sel_n_i, addr_i[4:0]}];
  end
  // Released bus must not echo stale data
  assign data_o = (!rd_n_i && !(&sel_n_i)) ? last : ~last;
endmodule
`default_nettype wire

// [tb/tb_external_zone_bus_interface.sv]
// Purpose: Self-checking bench for the external zone bus interface.
// Assumes: Mode pin low, so zone 7 starts unmapped.
// Notes:   Registers over AXI4-Lite, accesses over the CPU request port.
`timescale 1ns/1ps
`default_nettype none
module tb_external_zone_bus_interface;
  localparam logic [15:0] VER = 16'h005a; // Arbitrary version code
  logic clock_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, proc_mode_pin_i = 1'h0;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic [15:0] s_axi_awaddr_i = 16'h0, s_axi_araddr_i = 16'h0, req_wdata_i = 16'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic req_valid_i = 1'h0, req_write_i = 1'h0;
  logic [2:0] req_zone_i = 3'h0, seen = 3'h0;
  logic [18:0] req_addr_i = 19'h0, ext_addr_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic req_ready_o, req_done_o, req_err_o, ext_data_oe_o, ext_rd_n_o, ext_we_n_o;
  logic zone01_select_n_o, zone2_select_n_o, zone67_select_n_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [15:0] req_rdata_o, ext_data_o, ext_data_i;
  int err_total = 0;
  int checks = 0;
  wire [2:0] sel_n = {zone67_select_n_o, zone2_select_n_o, zone01_select_n_o};
  ////////////////////////////////////////////////////////////////////////////
  ext_zone_bus #(.VERSION_CODE(VER)) i_ext_zone_bus (.*);
  ext_mem_model i_ext_mem_model (.addr_i(ext_addr_o), .data_i(ext_data_o),
    .oe_i(ext_data_oe_o), .rd_n_i(ext_rd_n_o), .we_n_i(ext_we_n_o),
    .sel_n_i(sel_n), .data_o(ext_data_i));
  // 250 MHz clock
  always #2 clock_i = ~clock_i;
  // Selects seen low since the last taken request
  always @(posedge clock_i) seen <= (req_valid_i && req_ready_o) ? 3'h0 : seen | ~sel_n;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    logic aw_on, w_on, b_on;
    @(posedge clock_i);
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_awaddr_i <= {2'h0, idx, 2'h0};
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_bready_i <= 1'h1;
    // Own flags, since the driven signals only change after this time step
    {aw_on, w_on, b_on} = 3'h7;
    while (aw_on || w_on || b_on) begin
      @(posedge clock_i);
      if (b_on && s_axi_bvalid_o) r = s_axi_bresp_o;
      aw_on = aw_on && !s_axi_awready_o;
      w_on = w_on && !s_axi_wready_o;
      b_on = b_on && !s_axi_bvalid_o;
      s_axi_awvalid_i <= aw_on;
      s_axi_wvalid_i <= w_on;
      s_axi_bready_i <= b_on;
    end
  endtask
  task automatic axr(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ar_on, r_on;
    @(posedge clock_i);
    s_axi_arvalid_i <= 1'h1;
    s_axi_araddr_i <= {2'h0, idx, 2'h0};
    s_axi_rready_i <= 1'h1;
    {ar_on, r_on} = 2'h3;
    while (ar_on || r_on) begin
      @(posedge clock_i);
      if (r_on && s_axi_rvalid_o) begin
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
      end
      ar_on = ar_on && !s_axi_arready_o;
      r_on = r_on && !s_axi_rvalid_o;
      s_axi_arvalid_i <= ar_on;
      s_axi_rready_i <= r_on;
    end
  endtask
  // One CPU access; cycles counted from the taking edge to the answer
  task automatic acc(input logic wr, input logic [2:0] z, input logic [18:0] a,
                     input logic [15:0] d, input logic [2:0] sel, input int lo, input int hi);
    int n;
    @(posedge clock_i);
    req_valid_i <= 1'h1;
    req_write_i <= wr;
    req_zone_i <= z;
    req_addr_i <= a;
    req_wdata_i <= d;
    do @(posedge clock_i); while (req_ready_o !== 1'h1);
    req_valid_i <= 1'h0;
    n = 0;
    while (req_done_o !== 1'h1 && req_err_o !== 1'h1 && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    chk("access cycles", 32'(lo), (n >= lo && n <= hi) ? 32'(lo) : 32'(n));
    chk("error pulse", 32'(sel == 3'h0), 32'(req_err_o));
    chk("zone selects seen", 32'(sel), 32'(seen));
    chk("selects idle", 32'h7, 32'(sel_n));
    if (!wr && sel != 3'h0) chk("read data", 32'(d), 32'(req_rdata_o));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [11:0] idx [8];
    logic [31:0] d;
    logic [1:0] r;
    idx = '{12'hb20, 12'hb22, 12'hb24, 12'hb2c, 12'hb2e, 12'hb34, 12'hb38, 12'hb3a};
    for (int i = 0; i < 8; i++) begin
      axr(idx[i], d, r);
      chk("reset value", i < 5 ? 32'h1ff : i < 7 ? 32'(i == 5) : {16'h0, VER}, d);
    end
    axr(12'hb30, d, r);
    chk("unmapped resp", 32'h3, 32'(r));
    axw(12'hb3a, 32'h1234, 4'hf, r);
    chk("version write resp", 32'h2, 32'(r));
    axr(12'hb3a, d, r);
    chk("version kept", {16'h0, VER}, d);
    axw(12'hb24, 32'hffff_0000, 4'hc, r);
    axr(12'hb24, d, r);
    chk("upper half write", 32'h1ff, d);
    axw(12'hb24, 32'h89, 4'h3, r);
    chk("plain write resp", 32'h0, 32'(r));
    axr(12'hb24, d, r);
    chk("lower half write", 32'h89, d);
    axw(12'hb38, 32'hdead_c35a, 4'h3, r);
    axr(12'hb38, d, r);
    chk("bank half write", 32'hc35a, d);
    $display("test_regs done");
  endtask
  // Half rate from reset, then full rate on zone 2's own counts
  task automatic test_timing();
    logic [1:0] r;
    acc(1'h1, 3'h0, 19'h5, 16'hc3a5, 3'h1, 80, 81);
    axw(12'hb34, 32'h0, 4'h3, r);
    acc(1'h1, 3'h2, 19'h1, 16'h0f0f, 3'h2, 8, 8);
    acc(1'h0, 3'h2, 19'h1, 16'h0f0f, 3'h2, 8, 8);
    $display("test_timing done");
  endtask
  task automatic test_zones();
    logic [1:0] r;
    acc(1'h0, 3'h1, 19'h5, 16'hc3a5, 3'h1, 41, 41);
    acc(1'h1, 3'h6, 19'h3, 16'h5a5a, 3'h4, 41, 41);
    for (int z = 3; z < 6; z++) acc(1'h0, 3'(z), 19'h3, 16'h0, 3'h0, 1, 1);
    acc(1'h0, 3'h7, 19'h3, 16'h0, 3'h0, 1, 1);
    axw(12'hb34, 32'h100, 4'h3, r);
    acc(1'h0, 3'h7, 19'h3, 16'h5a5a, 3'h4, 41, 41);
    $display("test_zones done");
  endtask
  // Second reset with the mode pin high: strap maps zone 7, rate back to half
  task automatic test_strap();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clock_i);
    proc_mode_pin_i <= 1'h1;
    rst_i <= 1'h1;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'h0;
    axr(12'hb34, d, r);
    chk("mode strap", 32'h101, d);
    acc(1'h0, 3'h7, 19'h3, 16'h5a5a, 3'h4, 80, 81);
    $display("test_strap done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'h0;
    test_regs();
    test_timing();
    test_zones();
    test_strap();
    finish_test();
  end
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
